// ==== pkg/totalize_defs.vh ====
// Constants shared by the totalizer core and its input qualifier.
// Assumes inclusion by bare name from files under src/.
`ifndef TOTALIZE_DEFS_VH
`define TOTALIZE_DEFS_VH

// ----------------------------------------------------------------
// Register byte addresses (word aligned)
// ----------------------------------------------------------------
`define ADDR_CTRL        6'h00
`define ADDR_CMD         6'h04
`define ADDR_STATUS      6'h08
`define ADDR_COUNT_LO    6'h0C
`define ADDR_COUNT_HI    6'h10
`define ADDR_IRQ_STATUS  6'h14
`define ADDR_IRQ_CLEAR   6'h18
`define ADDR_IRQ_ENABLE  6'h1C

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define CTRL_MODE_LSB    0
`define CTRL_MODE_MSB    1
`define CTRL_START_LSB   2
`define CTRL_START_MSB   4
`define CTRL_STOP_LSB    5
`define CTRL_STOP_MSB    7
`define CTRL_SLOPE1_BIT  8
`define CTRL_SLOPE2_BIT  9
`define CTRL_SYNC_BIT    10
`define CTRL_WIDTH       11
`define CTRL_RESET       11'h000

// ----------------------------------------------------------------
// Command register bits (write only, self clearing)
// ----------------------------------------------------------------
`define CMD_INIT_BIT     0
`define CMD_STOP_NOW_BIT 1
`define CMD_BUS_ARM_BIT  2
`define CMD_ABORT_BIT    3

// ----------------------------------------------------------------
// Interrupt bits
// ----------------------------------------------------------------
`define IRQ_DONE_BIT     0
`define IRQ_GATE_BIT     1
`define IRQ_OVF_BIT      2
`define IRQ_ARM_BIT      3
`define IRQ_WIDTH        4
`define IRQ_RESET        4'h0

// ----------------------------------------------------------------
// Modes and arm sources
// ----------------------------------------------------------------
`define MODE_TOT1        2'h0
`define MODE_TOT1_BY2    2'h1
`define MODE_TOT2_BY1    2'h2
`define SRC_IMM          3'h0
`define SRC_HOLD         3'h1
`define SRC_BUS          3'h2
`define SRC_EXT          3'h3
`define SRC_TRIG_LINE    3'h4

// ----------------------------------------------------------------
// Counter range
// ----------------------------------------------------------------
`define COUNT_WIDTH      40
`define COUNT_MAX        40'hE8D4A50FFF
`define COUNT_ZERO       40'h0000000000

`endif

// ==== src/edge_qualifier.v ====
// Input qualifier: turns the two threshold comparator outputs of one
// channel into a single-cycle count event and a hysteresis level.
// Assumes asynchronous comparator pins and one core clock.
`include "totalize_defs.vh"

module edge_qualifier (
  input  wire core_clk,
  input  wire arst_n,
  input  wire above_hi,
  input  wire below_lo,
  input  wire slope_neg,
  output reg  event_q,
  output reg  level_q
);

  // ----------------------------------------------------------------
  // Two-stage synchronisers
  // ----------------------------------------------------------------
  reg hi_meta_q;
  reg hi_sync_q;
  reg lo_meta_q;
  reg lo_sync_q;
  reg low_seen_q;
  reg high_seen_q;

  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      hi_meta_q <= 1'b0;
      hi_sync_q <= 1'b0;
      lo_meta_q <= 1'b0;
      lo_sync_q <= 1'b0;
    end else begin
      hi_meta_q <= above_hi;
      hi_sync_q <= hi_meta_q;
      lo_meta_q <= below_lo;
      lo_sync_q <= lo_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // Hysteresis: an edge counts only after both thresholds are crossed
  // ----------------------------------------------------------------
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      low_seen_q  <= 1'b0;
      high_seen_q <= 1'b0;
      level_q     <= 1'b0;
      event_q     <= 1'b0;
    end else begin
      event_q <= 1'b0;
      if (hi_sync_q) begin
        level_q     <= 1'b1;
        low_seen_q  <= 1'b0;
        high_seen_q <= 1'b1;
        if (!slope_neg && low_seen_q)
          event_q <= 1'b1;
      end else if (lo_sync_q) begin
        level_q     <= 1'b0;
        high_seen_q <= 1'b0;
        low_seen_q  <= 1'b1;
        if (slope_neg && high_seen_q)
          event_q <= 1'b1;
      end
    end
  end

endmodule

// ==== src/totalize_arm_gate_control.v ====
// Totalizer with arming and gating control behind an Avalon-MM slave.
// Assumes comparator, external arm and trigger-line pins are asynchronous;
// bus master on core_clk.
//
// Operation
// - Count only while the gate is open.
// - Single channel: start arm opens, stop closes.
// - Start and stop arm sources are selectable.
// - Hold stop, and immediate stop in single channel mode, waits for stop command.
// - Gated modes: alternate channel drives the gate.
// - Gating recognised only between start and stop.
// - Gated completion: start, open, stop, close.
// - Immediate arms: gating signal alone sets interval.
// - Gated result read waits until gate closes.
// - Single channel read returns current count immediately.
// - Subtotal read neither stops nor clears count.
// - New measurement clears the final count.
// - No events between open and close reads zero.
// - Sync wait defers count reads until measurement completes.
// - Count only after both hysteresis thresholds crossed.
// - Count range up to ten^12 minus one.
// - Per-channel slope picks rising or falling edge.
//
// Decided for this implementation: the Avalon-MM slave port and the address map.
`include "totalize_defs.vh"

module totalize_arm_gate_control (
  input  wire        core_clk,
  input  wire        arst_n,
  input  wire [5:0]  address,
  input  wire        read,
  input  wire        write,
  input  wire [31:0] writedata,
  output reg  [31:0] readdata,
  output wire        waitrequest,
  input  wire        ch1_above_hi,
  input  wire        ch1_below_lo,
  input  wire        ch2_above_hi,
  input  wire        ch2_below_lo,
  input  wire        ext_arm,
  input  wire        trig_line,
  output reg         gate_open,
  output wire        irq
);

  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  localparam [2:0] ST_IDLE       = 3'h0;
  localparam [2:0] ST_WAIT_START = 3'h1;
  localparam [2:0] ST_ARMED      = 3'h2;
  localparam [2:0] ST_WAIT_CLOSE = 3'h3;
  localparam [2:0] ST_DONE       = 3'h4;

  reg [2:0]                state_q;
  reg [`CTRL_WIDTH-1:0]    ctrl_q;
  reg [`COUNT_WIDTH-1:0]   count_q;
  reg [`IRQ_WIDTH-1:0]     irq_status_q;
  reg [`IRQ_WIDTH-1:0]     irq_enable_q;
  reg                      seen_open_q;
  reg                      ack_q;
  reg [7:0]                hi_snap_q;
  reg                      ext_meta_q;
  reg                      ext_sync_q;
  reg                      ext_prev_q;
  reg                      trg_meta_q;
  reg                      trg_sync_q;
  reg                      trg_prev_q;

  wire                     ch1_event;
  wire                     ch1_level;
  wire                     ch2_event;
  wire                     ch2_level;

  // ----------------------------------------------------------------
  // Input channels
  // ----------------------------------------------------------------
  edge_qualifier u_ch1 (
    .core_clk  (core_clk),
    .arst_n    (arst_n),
    .above_hi  (ch1_above_hi),
    .below_lo  (ch1_below_lo),
    .slope_neg (ctrl_q[`CTRL_SLOPE1_BIT]),
    .event_q   (ch1_event),
    .level_q   (ch1_level)
  );

  edge_qualifier u_ch2 (
    .core_clk  (core_clk),
    .arst_n    (arst_n),
    .above_hi  (ch2_above_hi),
    .below_lo  (ch2_below_lo),
    .slope_neg (ctrl_q[`CTRL_SLOPE2_BIT]),
    .event_q   (ch2_event),
    .level_q   (ch2_level)
  );

  // ----------------------------------------------------------------
  // Arm pin synchronisers and edge detect
  // ----------------------------------------------------------------
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ext_meta_q <= 1'b0;
      ext_sync_q <= 1'b0;
      ext_prev_q <= 1'b0;
      trg_meta_q <= 1'b0;
      trg_sync_q <= 1'b0;
      trg_prev_q <= 1'b0;
    end else begin
      ext_meta_q <= ext_arm;
      ext_sync_q <= ext_meta_q;
      ext_prev_q <= ext_sync_q;
      trg_meta_q <= trig_line;
      trg_sync_q <= trg_meta_q;
      trg_prev_q <= trg_sync_q;
    end
  end

  wire ext_rise = ext_sync_q & ~ext_prev_q;
  wire trg_rise = trg_sync_q & ~trg_prev_q;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire [1:0] mode      = ctrl_q[`CTRL_MODE_MSB:`CTRL_MODE_LSB];
  wire [2:0] start_src = ctrl_q[`CTRL_START_MSB:`CTRL_START_LSB];
  wire [2:0] stop_src  = ctrl_q[`CTRL_STOP_MSB:`CTRL_STOP_LSB];
  wire       gated     = (mode == `MODE_TOT1_BY2) || (mode == `MODE_TOT2_BY1);
  wire       acquiring = (state_q == ST_WAIT_START) || (state_q == ST_ARMED) ||
                         (state_q == ST_WAIT_CLOSE);

  wire wr_take  = write & ack_q;
  wire cmd_wr   = wr_take && (address == `ADDR_CMD);
  wire init_cmd = cmd_wr && writedata[`CMD_INIT_BIT];
  wire stop_cmd = cmd_wr && writedata[`CMD_STOP_NOW_BIT];
  wire bus_cmd  = cmd_wr && writedata[`CMD_BUS_ARM_BIT];
  wire abort    = cmd_wr && writedata[`CMD_ABORT_BIT];

  // A count read during a gated or synchronised measurement is held off
  wire fetch_blocked = read && (address == `ADDR_COUNT_LO) && acquiring &&
                       (gated || ctrl_q[`CTRL_SYNC_BIT]);

  assign waitrequest = (read | write) & ~ack_q;

  // ----------------------------------------------------------------
  // Arm source decoding
  // ----------------------------------------------------------------
  function arm_hit;
    input [2:0] src;
    input       bus_now;
    input       ext_now;
    input       trg_now;
    begin
      case (src)
        `SRC_BUS:       arm_hit = bus_now;
        `SRC_HOLD:      arm_hit = bus_now;
        `SRC_EXT:       arm_hit = ext_now;
        `SRC_TRIG_LINE: arm_hit = trg_now;
        default:        arm_hit = 1'b0;
      endcase
    end
  endfunction

  // Immediate start fires at once
  wire start_ev = (start_src == `SRC_IMM) ||
                  arm_hit(start_src, bus_cmd, ext_rise, trg_rise);

  // Immediate or hold stop waits for the explicit command
  wire stop_hold = (stop_src == `SRC_IMM) || (stop_src == `SRC_HOLD);
  wire stop_ev   = stop_hold ? stop_cmd
                             : arm_hit(stop_src, bus_cmd, ext_rise, trg_rise);

  // In gated modes an immediate stop arms as soon as the gate has opened
  wire gated_stop = (stop_src == `SRC_IMM) ? 1'b1 : stop_ev;

  wire gate_level = (mode == `MODE_TOT1_BY2) ? ch2_level : ch1_level;
  wire count_ev   = (mode == `MODE_TOT2_BY1) ? ch2_event : ch1_event;

  // ----------------------------------------------------------------
  // Measurement sequencer
  // ----------------------------------------------------------------
  reg [2:0] state_d;
  reg       gate_d;
  reg       seen_open_d;

  always @* begin
    state_d     = state_q;
    gate_d      = gate_open;
    seen_open_d = seen_open_q;
    case (state_q)
      ST_IDLE: begin
        gate_d = 1'b0;
      end
      ST_WAIT_START: begin
        if (start_ev) begin
          state_d = ST_ARMED;
          gate_d  = ~gated;
        end
      end
      ST_ARMED: begin
        if (!gated) begin
          if (stop_ev) begin
            state_d = ST_DONE;
            gate_d  = 1'b0;
          end
        end else begin
          gate_d = gate_level;
          if (gate_level)
            seen_open_d = 1'b1;
          if (seen_open_q && gated_stop) begin
            if (gate_level) begin
              state_d = ST_WAIT_CLOSE;
            end else begin
              state_d = ST_DONE;
              gate_d  = 1'b0;
            end
          end
        end
      end
      ST_WAIT_CLOSE: begin
        // Reopening after stop arm is impossible: the gate only falls here
        if (!gate_level) begin
          state_d = ST_DONE;
          gate_d  = 1'b0;
        end
      end
      ST_DONE: begin
        gate_d = 1'b0;
      end
      default: begin
        state_d = ST_IDLE;
        gate_d  = 1'b0;
      end
    endcase
    if (abort) begin
      state_d = ST_IDLE;
      gate_d  = 1'b0;
    end
    if (init_cmd) begin
      state_d     = ST_WAIT_START;
      gate_d      = 1'b0;
      seen_open_d = 1'b0;
    end
  end

  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q     <= ST_IDLE;
      gate_open   <= 1'b0;
      seen_open_q <= 1'b0;
    end else begin
      state_q     <= state_d;
      gate_open   <= gate_d;
      seen_open_q <= seen_open_d;
    end
  end

  // ----------------------------------------------------------------
  // Accumulator
  // ----------------------------------------------------------------
  wire at_max = (count_q == `COUNT_MAX);

  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      count_q <= `COUNT_ZERO;
    end else if (init_cmd) begin
      count_q <= `COUNT_ZERO;
    end else if (gate_open && count_ev && !at_max) begin
      // Saturate rather than wrap at the top of range
      count_q <= count_q + 40'h0000000001;
    end
  end

  // ----------------------------------------------------------------
  // Registers and read path
  // ----------------------------------------------------------------
  wire [`IRQ_WIDTH-1:0] irq_set;
  assign irq_set[`IRQ_DONE_BIT] = (state_q != ST_DONE) && (state_d == ST_DONE);
  assign irq_set[`IRQ_GATE_BIT] = gate_d & ~gate_open;
  assign irq_set[`IRQ_OVF_BIT]  = gate_open && count_ev && at_max;
  assign irq_set[`IRQ_ARM_BIT]  = (state_q == ST_WAIT_START) && (state_d == ST_ARMED);

  wire [`IRQ_WIDTH-1:0] irq_clr = (wr_take && (address == `ADDR_IRQ_CLEAR)) ?
                                  writedata[`IRQ_WIDTH-1:0] : `IRQ_RESET;

  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_q       <= `CTRL_RESET;
      irq_enable_q <= `IRQ_RESET;
      irq_status_q <= `IRQ_RESET;
    end else begin
      if (wr_take && (address == `ADDR_CTRL))
        ctrl_q <= writedata[`CTRL_WIDTH-1:0];
      if (wr_take && (address == `ADDR_IRQ_ENABLE))
        irq_enable_q <= writedata[`IRQ_WIDTH-1:0];
      // Set wins over a clear landing in the same cycle
      irq_status_q <= (irq_status_q & ~irq_clr) | irq_set;
    end
  end

  assign irq = |(irq_status_q & irq_enable_q);

  // Read data comes from a flop one cycle after the request is seen
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ack_q     <= 1'b0;
      readdata  <= 32'h00000000;
      hi_snap_q <= 8'h00;
    end else if (ack_q) begin
      ack_q <= 1'b0;
    end else if ((read || write) && !fetch_blocked) begin
      ack_q <= 1'b1;
      if (read) begin
        case (address)
          `ADDR_CTRL:       readdata <= {21'h000000, ctrl_q};
          `ADDR_STATUS:     readdata <= {27'h0000000, seen_open_q, gate_open, state_q};
          `ADDR_COUNT_LO: begin
            // Snapshot keeps both halves coherent; counting goes on
            readdata  <= count_q[31:0];
            hi_snap_q <= count_q[39:32];
          end
          `ADDR_COUNT_HI:   readdata <= {24'h000000, hi_snap_q};
          `ADDR_IRQ_STATUS: readdata <= {28'h0000000, irq_status_q};
          `ADDR_IRQ_ENABLE: readdata <= {28'h0000000, irq_enable_q};
          default:          readdata <= 32'h00000000;
        endcase
      end
    end
  end

endmodule

// ==== tb/comp_source.sv ====
// Behavioural threshold comparator pair for one totalizer input channel.
// Assumes the core synchronises both levels itself; driven on core_clk.
module comp_source (
  input  wire  core_clk,
  output logic above_hi,
  output logic below_lo
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    above_hi = 1'b0;
    below_lo = 1'b1;
  end
  // ----
  // Waveforms
  // ----
  // Passes through the middle band so that both thresholds are crossed
  task automatic level(input logic up);
    @(posedge core_clk);
    above_hi <= 1'b0;
    below_lo <= 1'b0;
    repeat (4) @(posedge core_clk);
    above_hi <= up;
    below_lo <= !up;
    repeat (6) @(posedge core_clk);
  endtask
  task automatic swing(input int n);
    repeat (n) begin
      level(1'b1);
      level(1'b0);
    end
  endtask
  // Upper threshold only: a signal that never returns low must not recount
  task automatic glitch(input int n);
    repeat (n) begin
      @(posedge core_clk);
      below_lo <= 1'b0;
      above_hi <= 1'b1;
      repeat (4) @(posedge core_clk);
      above_hi <= 1'b0;
    end
  endtask
endmodule

// ==== tb/totalize_arm_gate_control_props.sv ====
// Port checker for the totalizer: bus answer timing, result hold-off, gate.
// Assumes it sees only top-level ports; bound below the module.
`include "totalize_defs.vh"

module totalize_arm_gate_control_props (
  input wire        core_clk,
  input wire        arst_n,
  input wire [5:0]  address,
  input wire        read,
  input wire        write,
  input wire [31:0] writedata,
  input wire [31:0] readdata,
  input wire        waitrequest,
  input wire        gate_open,
  input wire        irq
);
  timeunit 1ns;
  timeprecision 1ps;
  reg [1:0] mode_q;
  reg [2:0] stop_q;
  reg       sync_q;
  // ----
  // Control shadow, since the register itself is out of sight
  // ----
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_q <= 2'h0;
      stop_q <= 3'h0;
      sync_q <= 1'b0;
    end else if (write && !waitrequest && address == `ADDR_CTRL) begin
      mode_q <= writedata[1:0];
      stop_q <= writedata[7:5];
      sync_q <= writedata[10];
    end
  end
  // ----
  // Properties
  // ----
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!arst_n);
  sequence s_wr_acc;
    write && !waitrequest;
  endsequence
  sequence s_lo_wait;
    read && waitrequest && address == `ADDR_COUNT_LO;
  endsequence
  AST_IDLE_NOWAIT: assert property (!(read || write) |-> !waitrequest)
    else $error("Wait request without a request");
  AST_ONE_WAIT: assert property (
    (write || read && address != `ADDR_COUNT_LO) && waitrequest |=> !waitrequest)
    else $error("Request not answered after one wait cycle");
  AST_HI_BYTE: assert property (
    read && !waitrequest && address == `ADDR_COUNT_HI |-> readdata[31:8] == 24'h0)
    else $error("Upper count word wider than eight bits");
  AST_IRQ_MASKED: assert property (
    s_wr_acc ##0 (address == `ADDR_IRQ_ENABLE && writedata[3:0] == 4'h0) |=> !irq)
    else $error("Interrupt high with all enables clear");
  AST_STOP_CLOSES: assert property (
    s_wr_acc ##0 (address == `ADDR_CMD && writedata[1:0] == 2'h2 && mode_q == `MODE_TOT1
    && stop_q <= `SRC_HOLD) |=> ##[0:3] !gate_open)
    else $error("Gate still open after stop command");
  AST_GATE_HOLD: assert property (
    gate_open && mode_q == `MODE_TOT1 && stop_q <= `SRC_HOLD && !write && !$past(write)
    |=> gate_open)
    else $error("Gate closed without a stop command");
  AST_GATED_PEND: assert property (
    s_lo_wait ##0 (gate_open && mode_q != `MODE_TOT1) |=> waitrequest)
    else $error("Gated count answered while gate open");
  AST_SYNC_PEND: assert property (
    s_lo_wait ##0 (gate_open && sync_q) |=> waitrequest)
    else $error("Synchronised count answered while gate open");
  AST_TOT1_NOW: assert property (
    s_lo_wait ##0 (mode_q == `MODE_TOT1 && !sync_q) |=> !waitrequest)
    else $error("Single channel count not answered at once");
endmodule

bind totalize_arm_gate_control totalize_arm_gate_control_props
  props_inst (.core_clk(core_clk), .arst_n(arst_n), .address(address), .read(read),
  .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
  .gate_open(gate_open), .irq(irq));

// ==== tb/totalize_arm_gate_control_tb.sv ====
// Testbench for the totalizer: Avalon tasks, random bursts, gate checks.
// Assumes comp_source models both comparator pairs; checker is bound.
`include "totalize_defs.vh"

module totalize_arm_gate_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk, arst_n, read, write, ext_arm, trig_line;
  logic [5:0]  address;
  logic [31:0] writedata, rd;
  logic [39:0] cnt;
  logic [7:0]  lfsr_q;
  wire  [31:0] readdata;
  wire         waitrequest, gate_open, irq, h1, l1, h2, l2;
  int          errors, compares, n;

  totalize_arm_gate_control totalize_arm_gate_control_inst (.core_clk(core_clk),
    .arst_n(arst_n), .address(address), .read(read), .write(write), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest), .ch1_above_hi(h1), .ch1_below_lo(l1),
    .ch2_above_hi(h2), .ch2_below_lo(l2), .ext_arm(ext_arm), .trig_line(trig_line),
    .gate_open(gate_open), .irq(irq));
  comp_source ch1 (.core_clk(core_clk), .above_hi(h1), .below_lo(l1));
  comp_source ch2 (.core_clk(core_clk), .above_hi(h2), .below_lo(l2));

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  // ----
  // Tasks and expectations
  // ----
  task automatic check(input string what, input logic [39:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge core_clk);
  endtask
  // Blocked count reads can last a whole measurement, hence the long bound
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    int i;
    @(posedge core_clk);
    address <= a;
    // Reads carry random write data, which the slave must ignore
    writedata <= wr ? d : {4{lfsr_q}};
    write <= wr;
    read <= !wr;
    for (i = 0; i < 3000; i++) begin
      @(posedge core_clk);
      if (waitrequest === 1'b0)
        break;
    end
    rd = readdata;
    write <= 1'b0;
    read <= 1'b0;
    if (i == 3000) begin
      check("bus wait", 1'b1, 1'b0);
      finish_test();
    end
  endtask
  task automatic count();
    bus(1'b0, `ADDR_COUNT_LO, 32'h0);
    cnt[31:0] = rd;
    bus(1'b0, `ADDR_COUNT_HI, 32'h0);
    cnt[39:32] = rd[7:0];
  endtask
  task automatic gate_is(input logic v);
    for (int i = 0; i < 60 && gate_open !== v; i++)
      @(posedge core_clk);
    check("gate", gate_open, v);
  endtask
  task automatic pulse(input logic sel);
    @(posedge core_clk);
    ext_arm <= sel;
    trig_line <= !sel;
    cyc(4);
    ext_arm <= 1'b0;
    trig_line <= 1'b0;
    cyc(4);
  endtask
  function automatic logic [31:0] ctrl(input logic [1:0] md, input logic [2:0] st, sp, fl);
    return {21'h0, fl, sp, st, md};
  endfunction
  function automatic logic [39:0] edges(input logic neg, input int rises, falls);
    return neg ? falls : rises;
  endfunction
  function automatic logic [7:0] lfsr(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction
  // ----
  // Main sequence
  // ----
  initial begin
    arst_n = 1'b0;
    read = 1'b0;
    write = 1'b0;
    address = 6'h00;
    writedata = 32'h0;
    ext_arm = 1'b0;
    trig_line = 1'b0;
    errors = 0;
    compares = 0;
    lfsr_q = 8'h1F;
    cyc(20);
    arst_n <= 1'b1;
    bus(1'b0, `ADDR_CTRL, 32'h0);
    check("ctrl reset", rd, `CTRL_RESET);
    bus(1'b0, `ADDR_IRQ_STATUS, 32'h0);
    check("irq reset", rd, `IRQ_RESET);
    bus(1'b1, 6'h20, 32'hFFFFFFFF);
    bus(1'b0, 6'h20, 32'h0);
    check("unmapped", rd, 32'h0);
    for (int s = 0; s < 2; s++) begin
      bus(1'b1, `ADDR_CTRL, ctrl(`MODE_TOT1, `SRC_IMM, s ? `SRC_HOLD : `SRC_IMM, 3'(s)));
      bus(1'b1, `ADDR_IRQ_ENABLE, {20'h00000, lfsr_q, 4'h1});
      bus(1'b0, `ADDR_IRQ_ENABLE, 32'h0);
      check("irq enable", rd, 32'h1);
      bus(1'b1, `ADDR_CMD, 32'h1);
      gate_is(1'b1);
      bus(1'b0, `ADDR_STATUS, 32'h0);
      check("status", rd, 32'hA);
      ch1.level(1'b1);
      count();
      check("rise", cnt, edges(s, 1, 0));
      ch1.level(1'b0);
      lfsr_q = lfsr(lfsr_q);
      n = lfsr_q[2:0] + 1;
      ch1.swing(n);
      ch1.glitch(3);
      // Arm pins that are not selected must not end the measurement
      pulse(lfsr_q[3]);
      ch1.level(1'b0);
      count();
      check("subtotal", cnt, n + 2);
      check("open", gate_open, 1'b1);
      ch1.swing(2);
      count();
      check("subtotal2", cnt, n + 4);
      bus(1'b1, `ADDR_CMD, 32'h2);
      gate_is(1'b0);
      ch1.swing(2);
      count();
      check("final", cnt, n + 4);
      bus(1'b0, `ADDR_IRQ_STATUS, 32'h0);
      check("done", rd[3:0], 4'hB);
      check("irq", irq, 1'b1);
      bus(1'b1, `ADDR_IRQ_ENABLE, 32'h0);
      cyc(1);
      check("irq masked", irq, 1'b0);
      bus(1'b1, `ADDR_IRQ_CLEAR, 32'h1);
      bus(1'b0, `ADDR_IRQ_STATUS, 32'h0);
      check("cleared", rd[`IRQ_DONE_BIT], 1'b0);
      bus(1'b1, `ADDR_CMD, 32'h1);
      count();
      check("new count", cnt, 0);
      bus(1'b1, `ADDR_CMD, 32'h2);
      count();
      check("empty", cnt, 0);
    end
    for (int k = 0; k < 3; k++) begin
      bus(1'b1, `ADDR_CTRL, ctrl(`MODE_TOT1, 3'(`SRC_BUS + k), `SRC_HOLD, 3'h0));
      bus(1'b1, `ADDR_CMD, 32'h1);
      cyc(8);
      check("unarmed", gate_open, 1'b0);
      if (k == 0)
        bus(1'b1, `ADDR_CMD, 32'h4);
      else
        pulse(k == 1);
      gate_is(1'b1);
      bus(1'b1, `ADDR_CMD, 32'h2);
      gate_is(1'b0);
    end
    bus(1'b1, `ADDR_CTRL, ctrl(`MODE_TOT1, `SRC_IMM, `SRC_EXT, 3'h4));
    bus(1'b1, `ADDR_CMD, 32'h1);
    gate_is(1'b1);
    fork
      bus(1'b0, `ADDR_COUNT_LO, 32'h0);
      begin
        ch1.swing(2);
        pulse(1'b1);
      end
    join
    check("sync closed", gate_open, 1'b0);
    check("sync count", rd, 2);
    bus(1'b1, `ADDR_CTRL, ctrl(`MODE_TOT1_BY2, `SRC_BUS, `SRC_EXT, 3'h0));
    bus(1'b1, `ADDR_CMD, 32'h1);
    ch2.level(1'b1);
    check("early gate", gate_open, 1'b0);
    ch2.level(1'b0);
    bus(1'b1, `ADDR_CMD, 32'h4);
    ch2.level(1'b1);
    gate_is(1'b1);
    fork
      bus(1'b0, `ADDR_COUNT_LO, 32'h0);
      begin
        ch1.swing(3);
        pulse(1'b1);
        check("still open", gate_open, 1'b1);
        ch2.level(1'b0);
      end
    join
    check("gated count", rd, 3);
    ch2.level(1'b1);
    check("late gate", gate_open, 1'b0);
    ch2.level(1'b0);
    bus(1'b1, `ADDR_CTRL, ctrl(`MODE_TOT2_BY1, `SRC_IMM, `SRC_IMM, 3'h0));
    bus(1'b1, `ADDR_CMD, 32'h1);
    ch1.level(1'b1);
    gate_is(1'b1);
    ch2.swing(2);
    ch1.level(1'b0);
    gate_is(1'b0);
    count();
    check("interval", cnt, 2);
    ch1.level(1'b1);
    check("ended", gate_open, 1'b0);
    finish_test();
  end
endmodule
